// *** rsc_defs.vh ***
/*
 Constants for the reset source controller: register address, bit
 positions of the reset cause register, reset values and timing counts.
 Assumes it is included by bare name from the design file.
*/
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

`define RSC_REG_ADDR 8'hEF

`define RSC_BIT_PIN 0
`define RSC_BIT_PWR 1
`define RSC_BIT_CLK 2
`define RSC_BIT_WDT 3
`define RSC_BIT_SW 4
`define RSC_BIT_CMP 5
`define RSC_BIT_FLASH 6
`define RSC_BIT_RTC 7

`define RSC_FLAGS_POR 8'h02
`define RSC_PWR_EN_POR 1'b1

`define RSC_CLK_MHZ 50
`define RSC_CLK_LOSS_US 100
`define RSC_CLK_LOSS_CYC (`RSC_CLK_LOSS_US * `RSC_CLK_MHZ)

`define RSC_WDT_DIV 12
`define RSC_WDT_LIMIT 16'hFFFF
`define RSC_HOLD_CYC 16

`define RSC_ST_RUN 1'b0
`define RSC_ST_HOLD 1'b1

`endif

// *** rsc_reset_source_controller.v ***
/*
 Reset source controller: merges every reset request into one system
 reset, records the cause in the reset cause register and holds the
 enables for the switchable sources, plus the counter array watchdog.
 Assumes the special-function-register port and the source blocks run
 on sys_clk; the reset pin, comparator, clock monitor, supply monitor
 and real-time clock levels are asynchronous and are synchronised here.
*/
// Functional notes
// RULE1: Low reset pin forces reset; pin flag bit 0 set when leaving it.
// RULE2: Reset pin keeps working in suspend and sleep.
// RULE3: Enabled clock-loss detector resets after clock stalls over 100 us.
// RULE4: Bit 2 write enables clock-loss detector; reads 1 only after it.
// RULE5: Clock-loss reset blocked in low power, enable restored afterwards.
// RULE6: Bit 5 write selects comparator reset; reads 1 only after it.
// RULE7: Enabled comparator holds reset while plus input below minus; here the enable clears at reset entry, so reset ends after the hold.
// RULE8: Comparator reset works in low power if comparator wake enabled.
// RULE9: Software settles comparator before setting its reset enable.
// RULE10: Every reset leaves watchdog enabled, clocked at system clock/12.
// RULE11: Watchdog overflow resets and sets read-only flag bit 3.
// RULE12: Watchdog reset blocked in low power, enable restored afterwards.
// RULE13: Writes, code reads or fetches above lock byte cause flash error.
// RULE14: Security-blocked access or write without supply monitor too.
// RULE15: Flash error reset sets read-only flag bit 6.
// RULE16: Real-time clock requests reset on oscillator fail or alarm.
// RULE17: Bit 7 enables real-time clock reset, flags it, works asleep.
// RULE18: Writing 1 to bit 4 forces reset; bit reads 1 afterwards.
// RULE19: Internal resets never drive or change the reset pin.
// RULE20: Bit 1 enables supply monitor reset; reads 1 after power resets.
// RULE21: When bit 1 reads 1 the other bits are not meaningful.
// RULE22: Enabling supply reset before monitor settles may reset at once.
// RULE23: Software writes bit 1 as 1 on every register write.
// RULE24: Software enables the supply monitor before selecting it.
// RULE25: All enabled requests form one reset; causes captured at entry.
// RULE26: Bit 4 reads the recorded cause, not the written value.
`timescale 1ns/1ns
`include "rsc_defs.vh"

module rsc_reset_source_controller #(
    parameter CLK_LOSS_CYC = `RSC_CLK_LOSS_CYC,
    parameter HOLD_CYC = `RSC_HOLD_CYC,
    parameter [15:0] WDT_LIMIT = `RSC_WDT_LIMIT,
    parameter AW = 16
) (
    // Clock, reset, enable
    input wire sys_clk,
    input wire rst,
    input wire ce,
    // Register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata_q,
    // Asynchronous source levels
    input wire reset_pin_n,
    input wire comparator_above,
    input wire clock_monitor,
    input wire supply_low,
    input wire rtc_clk_slow,
    input wire rtc_alarm_match,
    // Source settings, same clock domain
    input wire low_power,
    input wire cmp_wake_en,
    input wire rtc_loss_det_en,
    input wire rtc_alarm_en,
    input wire supply_monitor_enable,
    // Watchdog control, same clock domain
    input wire wdt_disable,
    input wire wdt_kick,
    // Flash access monitor, same clock domain
    input wire [AW-1:0] flash_addr,
    input wire [AW-1:0] lock_addr,
    input wire external_data_move_wr,
    input wire flash_write_enable,
    input wire code_data_move,
    input wire instr_fetch,
    input wire flash_wr_erase,
    input wire security_block,
    // Results
    output reg sys_reset_q,
    output reg wdt_running_q
);

    function above_lock;
        input [AW-1:0] a;
        input [AW-1:0] lim;
        begin
            above_lock = a > lim;
        end
    endfunction

    localparam SN = 6;
    localparam [31:0] WDT_DIV_LAST = `RSC_WDT_DIV - 1;

    reg [SN-1:0] sync1_q;
    reg [SN-1:0] sync2_q;
    reg mon_prev_q;
    reg state_q;
    reg [15:0] hold_q;
    reg [31:0] loss_q;
    reg [3:0] wdt_pre_q;
    reg [15:0] wdt_cnt_q;
    reg wdt_ovf_q;
    reg [7:0] flags_q;
    reg clk_en_q;
    reg cmp_en_q;
    reg rtc_en_q;
    reg pwr_en_q;
    reg sw_req_q;

    wire [SN-1:0] raw;
    wire pin_s;
    wire cmp_s;
    wire mon_s;
    wire sup_s;
    wire rslow_s;
    wire ralarm_s;
    wire req_pin;
    wire req_clk;
    wire req_cmp;
    wire req_wdt;
    wire req_flash;
    wire req_rtc;
    wire req_pwr;
    wire any_req;
    wire reg_wr;
    wire [7:0] cause;

    assign raw = {rtc_alarm_match, rtc_clk_slow, supply_low,
        clock_monitor, comparator_above, reset_pin_n};
    assign pin_s = sync2_q[0];
    assign cmp_s = sync2_q[1];
    assign mon_s = sync2_q[2];
    assign sup_s = sync2_q[3];
    assign rslow_s = sync2_q[4];
    assign ralarm_s = sync2_q[5];

    // No low-power gating on the pin path [RULE2]
    assign req_pin = ~pin_s; // [RULE1]
    // Stall counter only runs when the detector is enabled and awake
    assign req_clk = clk_en_q & ~low_power
        & (loss_q >= CLK_LOSS_CYC); // [RULE3] [RULE5]
    // Comparator output acts as an active-low reset [RULE7]
    assign req_cmp = cmp_en_q & ~cmp_s
        & (~low_power | cmp_wake_en); // [RULE8]
    assign req_wdt = wdt_ovf_q & ~low_power; // [RULE12]
    assign req_flash = (external_data_move_wr & flash_write_enable
        & above_lock(flash_addr, lock_addr))
        | (code_data_move & above_lock(flash_addr, lock_addr))
        | (instr_fetch & above_lock(flash_addr, lock_addr)) // [RULE13]
        | security_block
        | (flash_wr_erase & ~supply_monitor_enable); // [RULE14]
    // Real-time clock stays armed in low power
    assign req_rtc = rtc_en_q & ((rtc_loss_det_en & rslow_s)
        | (rtc_alarm_en & ralarm_s)); // [RULE16] [RULE17]
    // Selecting the supply while it is still low resets at once [RULE22]
    assign req_pwr = pwr_en_q & supply_monitor_enable & sup_s;
    assign any_req = req_pin | req_clk | req_cmp | req_wdt
        | req_flash | req_rtc | req_pwr | sw_req_q; // [RULE25]

    assign cause = {req_rtc, req_flash, req_cmp, sw_req_q,
        req_wdt, req_clk, req_pwr, req_pin};
    assign reg_wr = sfr_wr & (sfr_addr == `RSC_REG_ADDR) & ~sys_reset_q;

    // The pin is input only here, so no internal reset can reach it
    // [RULE19]
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= {SN{1'b0}};
            sync2_q <= {SN{1'b0}};
            mon_prev_q <= 1'b0;
        end else if (ce) begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
            mon_prev_q <= mon_s;
        end
    end

    // Edges of the monitored clock restart the stall count
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            loss_q <= 32'h00000000;
        end else if (ce) begin
            if (mon_s != mon_prev_q || !clk_en_q || low_power) begin
                loss_q <= 32'h00000000;
            end else if (loss_q < CLK_LOSS_CYC) begin
                loss_q <= loss_q + 32'h00000001; // [RULE3]
            end
        end
    end

    // Reset sequencer: entry captures the cause, exit after a quiet hold
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= `RSC_ST_HOLD;
            hold_q <= 16'h0000;
            sys_reset_q <= 1'b1;
            flags_q <= `RSC_FLAGS_POR;
        end else if (ce) begin
            case (state_q)
                `RSC_ST_RUN: begin
                    if (any_req) begin
                        state_q <= `RSC_ST_HOLD;
                        sys_reset_q <= 1'b1;
                        hold_q <= 16'h0000;
                        flags_q <= cause; // [RULE25] [RULE11] [RULE15]
                    end
                end
                `RSC_ST_HOLD: begin
                    if (any_req) begin
                        hold_q <= 16'h0000;
                    end else if (hold_q >= HOLD_CYC[15:0]) begin
                        // Pin flag already captured, shows on exit [RULE1]
                        state_q <= `RSC_ST_RUN;
                        sys_reset_q <= 1'b0;
                    end else begin
                        hold_q <= hold_q + 16'h0001;
                    end
                end
                default: begin
                    state_q <= `RSC_ST_HOLD;
                    sys_reset_q <= 1'b1;
                end
            endcase
        end
    end

    // Enables; the power-fail enable survives internal resets
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_en_q <= 1'b0;
            cmp_en_q <= 1'b0;
            rtc_en_q <= 1'b0;
            pwr_en_q <= `RSC_PWR_EN_POR;
            sw_req_q <= 1'b0;
        end else if (ce) begin
            sw_req_q <= 1'b0;
            if (sys_reset_q) begin
                clk_en_q <= 1'b0;
                cmp_en_q <= 1'b0;
                rtc_en_q <= 1'b0;
            end else if (reg_wr) begin
                // Held enables are untouched by low power [RULE5]
                clk_en_q <= sfr_wdata[`RSC_BIT_CLK]; // [RULE4]
                cmp_en_q <= sfr_wdata[`RSC_BIT_CMP]; // [RULE6]
                rtc_en_q <= sfr_wdata[`RSC_BIT_RTC]; // [RULE17]
                pwr_en_q <= sfr_wdata[`RSC_BIT_PWR]; // [RULE20]
                sw_req_q <= sfr_wdata[`RSC_BIT_SW]; // [RULE18]
            end
        end
    end

    // Watchdog: prescale by 12, overflow on the tick after the count reaches the limit
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wdt_running_q <= 1'b1;
            wdt_pre_q <= 4'h0;
            wdt_cnt_q <= 16'h0000;
            wdt_ovf_q <= 1'b0;
        end else if (ce) begin
            if (sys_reset_q) begin
                wdt_running_q <= 1'b1; // [RULE10]
                wdt_pre_q <= 4'h0;
                wdt_cnt_q <= 16'h0000;
                wdt_ovf_q <= 1'b0;
            end else begin
                if (wdt_disable) begin
                    wdt_running_q <= 1'b0;
                end
                if (wdt_kick) begin
                    wdt_cnt_q <= 16'h0000;
                    wdt_pre_q <= 4'h0;
                end else if (wdt_running_q && !low_power) begin
                    // Count freezes asleep so the setting resumes [RULE12]
                    if (wdt_pre_q == WDT_DIV_LAST[3:0]) begin
                        wdt_pre_q <= 4'h0; // [RULE10]
                        if (wdt_cnt_q == WDT_LIMIT) begin
                            wdt_ovf_q <= 1'b1; // [RULE11]
                        end else begin
                            wdt_cnt_q <= wdt_cnt_q + 16'h0001;
                        end
                    end else begin
                        wdt_pre_q <= wdt_pre_q + 4'h1;
                    end
                end
            end
        end
    end

    // Read data: bit 4 shows the captured cause, never the write [RULE26]
    // Other bits carry no meaning while bit 1 is set [RULE21]
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata_q <= 8'h00;
        end else if (ce) begin
            if (sfr_addr == `RSC_REG_ADDR) begin
                sfr_rdata_q <= flags_q; // [RULE4] [RULE6] [RULE20]
            end else begin
                sfr_rdata_q <= 8'h00;
            end
        end
    end

endmodule

// *** rsc_src_model.sv ***
/* Far-side model: reset pin with pull-up, comparator, watched clock and
   real-time clock events. Assumes the bench steers it by plain levels. */
`timescale 1ns/1ns
module rsc_src_model (
    // Controls from the bench
    input wire pin_low,
    input wire cmp_low,
    input wire clk_stop,
    input wire [1:0] rtc_ev,
    // Source levels
    output wire reset_pin_n,
    output wire comparator_above,
    output wire rtc_alarm_match,
    output wire rtc_clk_slow,
    output reg clock_monitor
);
    // Pull-up keeps the pin high whenever nobody pulls it down
    assign reset_pin_n = !pin_low;
    // Output starts settled high, so setting its reset enable is safe
    assign comparator_above = !cmp_low;
    assign rtc_alarm_match = rtc_ev[0];
    assign rtc_clk_slow = rtc_ev[1];
    initial clock_monitor = 1'b0;
    // Unrelated to sys_clk on purpose; frozen level models a lost clock
    always #30 if (!clk_stop) clock_monitor = !clock_monitor;
endmodule

// *** rsc_chk_sva.sv ***
/* Checker for the reset source controller ports.
   Assumes binding to the design top; watches design inputs and outputs. */
`timescale 1ns/1ns
module rsc_chk #(parameter AW = 16) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    input wire ce,
    // Register port
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata_q,
    input wire sfr_wr,
    // Sources and flash monitor
    input wire reset_pin_n,
    input wire low_power,
    input wire supply_monitor_enable,
    input wire [AW-1:0] flash_addr,
    input wire [AW-1:0] lock_addr,
    input wire external_data_move_wr,
    input wire flash_write_enable,
    input wire code_data_move,
    input wire instr_fetch,
    input wire flash_wr_erase,
    input wire security_block,
    // Results
    input wire sys_reset_q,
    input wire wdt_running_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire run = ce && !sys_reset_q;
    wire above = flash_addr > lock_addr;
    pin_hold_a: assert property (
        (ce && !reset_pin_n) [*4] |-> sys_reset_q)
        else $error("pin held low without system reset");
    soft_force_a: assert property (
        run && sfr_wr && sfr_addr == 8'hEF && sfr_wdata[4]
        |-> ##2 sys_reset_q)
        else $error("software force did not reset");
    hold_time_a: assert property (
        $rose(sys_reset_q) |=> sys_reset_q [*8])
        else $error("system reset too short");
    wdt_restart_a: assert property (
        $fell(sys_reset_q) |-> wdt_running_q)
        else $error("watchdog not running after reset");
    fetch_read_a: assert property (
        run && above && (instr_fetch || code_data_move) |=> sys_reset_q)
        else $error("read above lock byte not reset");
    move_write_a: assert property (
        run && above && external_data_move_wr && flash_write_enable
        |=> sys_reset_q)
        else $error("write above lock byte not reset");
    secure_nomon_a: assert property (
        run && (security_block || flash_wr_erase && !supply_monitor_enable)
        |=> sys_reset_q)
        else $error("blocked flash access not reset");
    read_zero_a: assert property (
        ce && sfr_addr != 8'hEF |=> sfr_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    cover property (run && sfr_wr && sfr_wdata[4]);
    cover property (low_power && $rose(sys_reset_q));
    cover property (sfr_addr == 8'hEF ##1 sfr_rdata_q != 8'h00);
endmodule
bind rsc_reset_source_controller rsc_chk #(.AW(AW)) rsc_chk_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata_q(sfr_rdata_q),
    .sfr_wr(sfr_wr),
    .reset_pin_n(reset_pin_n),
    .low_power(low_power),
    .supply_monitor_enable(supply_monitor_enable),
    .flash_addr(flash_addr),
    .lock_addr(lock_addr),
    .external_data_move_wr(external_data_move_wr),
    .flash_write_enable(flash_write_enable),
    .code_data_move(code_data_move),
    .instr_fetch(instr_fetch),
    .flash_wr_erase(flash_wr_erase),
    .security_block(security_block),
    .sys_reset_q(sys_reset_q),
    .wdt_running_q(wdt_running_q)
);

// *** rsc_reset_source_controller_bench.sv ***
/* Bench for the reset source controller: register calls and source
   events; each reset is followed by a read of the recorded cause. */
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    fail_count++; $display("unexpected at %0t: got %h want %h", \
    $time, a, b); end end
module rsc_reset_source_controller_bench;
    logic sys_clk, rst, ce, sfr_wr, low_power, cmp_wake_en, wdt_kick;
    logic rtc_loss_det_en, rtc_alarm_en, supply_monitor_enable, supply_low;
    logic wdt_disable, pin_low, cmp_low, clk_stop, kick_on;
    logic [7:0] sfr_addr, sfr_wdata;
    logic [15:0] flash_addr, lock_addr;
    logic [1:0] rtc_ev;
    logic [4:0] fl;
    wire [7:0] sfr_rdata_q;
    wire reset_pin_n, comparator_above, clock_monitor, rtc_clk_slow;
    wire rtc_alarm_match, sys_reset_q, wdt_running_q, flash_write_enable;
    wire external_data_move_wr, security_block, instr_fetch;
    wire code_data_move, flash_wr_erase;
    int fail_count = 0;
    int comparisons = 0;
    assign {external_data_move_wr, security_block, instr_fetch,
        code_data_move, flash_wr_erase} = fl;
    assign flash_write_enable = fl[4];
    rsc_reset_source_controller #(
        .CLK_LOSS_CYC(20),
        .HOLD_CYC(16),
        .WDT_LIMIT(16'h0004),
        .AW(16)
    ) rsc_reset_source_controller_i (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata_q(sfr_rdata_q),
        .reset_pin_n(reset_pin_n),
        .comparator_above(comparator_above),
        .clock_monitor(clock_monitor),
        .supply_low(supply_low),
        .rtc_clk_slow(rtc_clk_slow),
        .rtc_alarm_match(rtc_alarm_match),
        .low_power(low_power),
        .cmp_wake_en(cmp_wake_en),
        .rtc_loss_det_en(rtc_loss_det_en),
        .rtc_alarm_en(rtc_alarm_en),
        .supply_monitor_enable(supply_monitor_enable),
        .wdt_disable(wdt_disable),
        .wdt_kick(wdt_kick),
        .flash_addr(flash_addr),
        .lock_addr(lock_addr),
        .external_data_move_wr(external_data_move_wr),
        .flash_write_enable(flash_write_enable),
        .code_data_move(code_data_move),
        .instr_fetch(instr_fetch),
        .flash_wr_erase(flash_wr_erase),
        .security_block(security_block),
        .sys_reset_q(sys_reset_q),
        .wdt_running_q(wdt_running_q)
    );
    rsc_src_model rsc_src_model_i (
        .pin_low(pin_low),
        .cmp_low(cmp_low),
        .clk_stop(clk_stop),
        .rtc_ev(rtc_ev),
        .reset_pin_n(reset_pin_n),
        .comparator_above(comparator_above),
        .rtc_alarm_match(rtc_alarm_match),
        .rtc_clk_slow(rtc_clk_slow),
        .clock_monitor(clock_monitor)
    );
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = !sys_clk;
    end
    // Sole driver of the kick; an unknown start still yields a kick
    always @(negedge sys_clk) wdt_kick <= kick_on && (wdt_kick !== 1'b1);
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input [7:0] d);
        @(negedge sys_clk);
        sfr_addr = 8'hEF;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [7:0] e);
        @(negedge sys_clk);
        sfr_addr = a;
        @(negedge sys_clk);
        `CHK(sfr_rdata_q, e)
    endtask
    // Bounded wait for a reset level; running out ends the run
    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        while (sys_reset_q !== lvl) begin
            @(negedge sys_clk);
            n++;
            if (n > 400) begin
                fail_count++;
                end_of_test();
            end
        end
    endtask
    task automatic cause(input string nm, input [7:0] e);
        wait_rst(1'b1);
        wait_rst(1'b0);
        rd(8'hEF, e);
        rd(8'h00, 8'h00);
        $display("test %0s done", nm);
    endtask
    initial begin
        // Monitor is on before any write selects it
        {rst, ce, kick_on, supply_monitor_enable} = 4'hF;
        {sfr_wr, low_power, cmp_wake_en, wdt_disable} = 4'h0;
        {rtc_loss_det_en, rtc_alarm_en, supply_low, pin_low} = 4'h0;
        {cmp_low, clk_stop, rtc_ev, fl} = 9'h000;
        {sfr_addr, sfr_wdata} = 16'h0000;
        flash_addr = 16'hF000;
        lock_addr = 16'h8000;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) rst = 1'b0;
        cause("power_on", 8'h02);
        wr(8'h12);
        cause("software", 8'h10);
        @(negedge sys_clk) wdt_disable = 1'b1;
        @(negedge sys_clk) wdt_disable = 1'b0;
        `CHK(wdt_running_q, 1'b0)
        pin_low = 1'b1;
        low_power = 1'b1;
        repeat (6) @(negedge sys_clk);
        {pin_low, low_power} = 2'b00;
        cause("pin", 8'h01);
        `CHK(wdt_running_q, 1'b1)
        wr(8'h06);
        wr(8'h02);
        clk_stop = 1'b1;
        repeat (60) @(negedge sys_clk);
        `CHK(sys_reset_q, 1'b0)
        clk_stop = 1'b0;
        wr(8'h06);
        {low_power, clk_stop} = 2'b11;
        repeat (60) @(negedge sys_clk);
        `CHK(sys_reset_q, 1'b0)
        low_power = 1'b0;
        cause("clock_loss", 8'h04);
        clk_stop = 1'b0;
        {low_power, cmp_wake_en} = 2'b11;
        wr(8'h22);
        cmp_low = 1'b1;
        cause("comparator", 8'h20);
        {cmp_low, kick_on} = 2'b00;
        repeat (150) @(negedge sys_clk);
        `CHK(sys_reset_q, 1'b0)
        low_power = 1'b0;
        cause("watchdog", 8'h08);
        kick_on = 1'b1;
        for (int i = 0; i < 5; i++) begin
            supply_monitor_enable = i != 0;
            @(negedge sys_clk) fl = 5'h01 << i;
            @(negedge sys_clk) fl = 5'h00;
            cause("flash", 8'h40);
        end
        {supply_monitor_enable, rtc_alarm_en, rtc_loss_det_en} = 3'h7;
        low_power = 1'b1;
        for (int i = 1; i < 3; i++) begin
            wr(8'h82);
            rtc_ev = i[1:0];
            cause("rtc", 8'h80);
            rtc_ev = 2'b00;
        end
        // Power-fail enable survived every internal reset
        supply_low = 1'b1;
        repeat (4) @(negedge sys_clk);
        supply_low = 1'b0;
        cause("supply", 8'h02);
        end_of_test();
    end
endmodule
